// file: core/usb_flag_pkg.sv
// package: register map, field positions, reset values and timing of the usb event flag block
`default_nettype none
package usb_flag_pkg;
   // ***********************************************
   // register offsets (byte addresses, one word each)
   // ***********************************************
   localparam logic [7:0] OFS_FLAGS = 8'h00;
   localparam logic [7:0] OFS_MASK = 8'h04;
   localparam logic [7:0] OFS_CTRL = 8'h08;
   localparam logic [7:0] OFS_ERR_MASK = 8'h0C;
   localparam logic [7:0] OFS_XFER_STAT = 8'h10;
   localparam logic [7:0] OFS_UNMAPPED = 8'hFF; // tag for addresses above the map

   // ***********************************************
   // field positions and reset values
   // ***********************************************
   localparam int BIT_STALL = 7;
   localparam int BIT_ATTACH = 6;
   localparam int BIT_RESUME = 5;
   localparam int BIT_IDLE = 4;
   localparam int BIT_TOKEN = 3;
   localparam int BIT_SOF = 2;
   localparam int BIT_ERROR = 1;
   localparam int BIT_RST_DET = 0;
   localparam int BIT_HOST_EN = 0;
   localparam logic [7:0] FLAG_W1C_MASK = 8'hBF;
   localparam logic [7:0] FLAGS_RESET = 8'h00;
   localparam logic [7:0] MASK_RESET = 8'h00;
   localparam logic CTRL_RESET = 1'b0;
   localparam logic [7:0] ERR_MASK_RESET = 8'hFF;
   localparam logic [2:0] SIZE_WORD = 3'h2;

   // line state codes as seen on the transceiver
   localparam logic [1:0] LS_SE0 = 2'h0;
   localparam logic [1:0] LS_J = 2'h1;
   localparam logic [1:0] LS_K = 2'h2;

   // ***********************************************
   // timing, clock 125 MHz
   // ***********************************************
   localparam real CLK_PERIOD_NS = 8.0;
   localparam real QUIET_TIME_US = 2.5;
   localparam real IDLE_TIME_MS = 3.0;
   localparam int QUIET_CYC = int'($ceil(QUIET_TIME_US * 1000.0 / CLK_PERIOD_NS));
   localparam int IDLE_CYC = int'($ceil(IDLE_TIME_MS * 1000000.0 / CLK_PERIOD_NS));

   // data phase of the register bus
   typedef enum logic [2:0] {
      PH_IDLE = 3'b001,
      PH_WRITE = 3'b010,
      PH_READ = 3'b100
   } phase_t;
endpackage
`default_nettype wire

// file: core/line_state_monitor.sv
// module: timed line state detector for attach, detach, resume and idle events
`default_nettype none
module line_state_monitor
   import usb_flag_pkg::*;
#(
   parameter int QUIET_CYCLES = QUIET_CYC,
   parameter int IDLE_CYCLES = IDLE_CYC,
   parameter int CNT_W = 20
) (
   input wire logic clock,
   input wire logic sys_rst,
   input wire logic [1:0] line_state,
   input wire logic bus_activity,
   input wire logic host_en,
   output logic attached,
   output logic attach_evt,
   output logic detach_evt,
   output logic resume_evt,
   output logic idle_evt
);
   logic [1:0] prev_r;
   logic [CNT_W-1:0] hold_r;
   logic attached_r;
   logic quiet_hit;

   // cycles the line has kept one state with no packet traffic; saturates
   always_ff @(posedge clock or posedge sys_rst) begin
      if (sys_rst) begin
         prev_r <= LS_SE0;
         hold_r <= '0;
      end else begin
         prev_r <= line_state;
         if (bus_activity || line_state != prev_r) begin
            hold_r <= '0;
         end else if (hold_r != {CNT_W{1'b1}}) begin
            hold_r <= hold_r + CNT_W'(1);
         end
      end
   end

   assign quiet_hit = (line_state == prev_r) && !bus_activity &&
      (hold_r == CNT_W'(QUIET_CYCLES - 1));
   // each event pulses once, at the cycle the hold time is reached
   assign resume_evt = quiet_hit && line_state == LS_K;
   assign idle_evt = (line_state == prev_r) && !bus_activity && line_state == LS_J &&
      (hold_r == CNT_W'(IDLE_CYCLES - 1));
   assign attach_evt = host_en && !attached_r && quiet_hit && line_state != LS_SE0;
   assign detach_evt = host_en && attached_r && quiet_hit && line_state == LS_SE0;
   assign attached = attached_r;

   // attachment memory; meaningless outside host role, so dropped there
   always_ff @(posedge clock or posedge sys_rst) begin
      if (sys_rst) begin
         attached_r <= 1'b0;
      end else if (!host_en || detach_evt) begin
         attached_r <= 1'b0;
      end else if (attach_evt) begin
         attached_r <= 1'b1;
      end
   end

   default clocking cb @(posedge clock); endclocking
   default disable iff (sys_rst);

   a_resume_k_held: assert property (
      resume_evt |-> line_state == LS_K && $past(line_state) == LS_K && !$past(bus_activity))
      else $error("resume pulse without a held K state");
   a_idle_single: assert property (
      idle_evt |=> !idle_evt)
      else $error("idle pulse repeated");
   a_attach_then_flag: assert property (
      attach_evt |=> attached && !attach_evt)
      else $error("attachment not remembered");
endmodule
`default_nettype wire

// file: core/usb_event_flag_register.sv
// module: usb event flag register with mask, status fifo and ahb-lite slave
// Contract
// - host role: received stall handshake sets flag bit 7
// - function role: transmitted stall handshake sets the same bit 7
// - host role: attachment after 2.5 us quiet, non-SE0 bus sets bit 6
// - K state held 2.5 us sets resume flag bit 5
// - idle state held 3 ms or longer sets idle flag bit 4
// - finished token sets bit 3; transfer status shows that token's entry
// - clearing token-done advances the status fifo to the next entry
// - sof received as function, or threshold reached as host, sets bit 2
// - any unmasked error condition sets error summary bit 1
// - function role: valid bus reset sets bit 0
// - host role: bit 0 flags detachment of the peripheral
// - bits 7,5..0 set by hardware, write-one clears; bit 6 read-only; reset zero
// - bits 31..8 of the flag register read as zero
`default_nettype none
module usb_event_flag_register
   import usb_flag_pkg::*;
#(
   parameter int QUIET_CYCLES = QUIET_CYC,
   parameter int IDLE_CYCLES = IDLE_CYC,
   parameter int XFER_DEPTH = 4,
   parameter int STAT_W = 8,
   parameter int ERR_W = 8
) (
   input wire logic clock,
   input wire logic sys_rst,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic hreadyout,
   output logic [31:0] hrdata,
   output logic hresp,
   input wire logic [1:0] line_state,
   input wire logic bus_activity,
   input wire logic stall_rx,
   input wire logic stall_tx,
   input wire logic token_done,
   input wire logic [STAT_W-1:0] token_status,
   output logic token_ready,
   input wire logic sof_rx,
   input wire logic sof_threshold,
   input wire logic [ERR_W-1:0] error_events,
   input wire logic usb_reset_rx,
   output logic host_role_enable,
   output logic irq
);
   localparam int PTR_W = (XFER_DEPTH > 1) ? $clog2(XFER_DEPTH) : 1;
   localparam int CNT_W = $clog2(XFER_DEPTH + 1);

   // ***********************************************
   // register bus slave
   // ***********************************************
   phase_t ph_r;
   logic [7:0] addr_r;
   logic [31:0] hrdata_r;
   logic [31:0] rd_mux;
   logic accept;
   logic wr_flags;
   logic wr_mask;
   logic wr_ctrl;
   logic wr_err_mask;

   // state registers
   logic [7:0] flags_r;
   logic [7:0] flags_nxt;
   logic [7:0] mask_r;
   logic host_en_r;
   logic [ERR_W-1:0] err_mask_r;
   logic [7:0] flag_set;
   logic [7:0] flag_clr;

   // status fifo
   logic [STAT_W-1:0] stat_mem_r [XFER_DEPTH];
   logic [PTR_W-1:0] wr_ptr_r;
   logic [PTR_W-1:0] rd_ptr_r;
   logic [CNT_W-1:0] count_r;
   logic push;
   logic pop;

   // line state events
   logic attached;
   logic attach_evt;
   logic detach_evt;
   logic resume_evt;
   logic idle_evt;

   // zero wait states: every transfer completes in its first data cycle
   assign hreadyout = 1'b1;
   assign hresp = 1'b0;
   assign hrdata = hrdata_r;
   assign accept = hsel && htrans[1] && hready;

   // address phase capture; upper address bits off the map go to an unmapped tag
   always_ff @(posedge clock or posedge sys_rst) begin
      if (sys_rst) begin
         ph_r <= PH_IDLE;
         addr_r <= 8'h00;
      end else if (accept) begin
         addr_r <= (haddr[31:8] == 24'h000000) ? haddr[7:0] : OFS_UNMAPPED;
         if (!hwrite) begin
            ph_r <= PH_READ;
         end else if (hsize == SIZE_WORD) begin
            ph_r <= PH_WRITE;
         end else begin
            ph_r <= PH_IDLE; // only whole words are written
         end
      end else if (hready) begin
         ph_r <= PH_IDLE;
      end
   end

   // read multiplexer, evaluated on the address phase
   always_comb begin
      rd_mux = 32'h00000000;
      if (haddr[31:8] == 24'h000000) begin
         case (haddr[7:0])
            OFS_FLAGS: rd_mux = {24'h000000, flags_r};
            OFS_MASK: rd_mux = {24'h000000, mask_r};
            OFS_CTRL: rd_mux = {31'h00000000, host_en_r};
            OFS_ERR_MASK: rd_mux = 32'(err_mask_r);
            OFS_XFER_STAT: rd_mux = (count_r != '0) ? 32'(stat_mem_r[rd_ptr_r]) : 32'h0;
            default: rd_mux = 32'h00000000;
         endcase
      end
   end

   // read data is registered at the end of the address phase
   always_ff @(posedge clock or posedge sys_rst) begin
      if (sys_rst) begin
         hrdata_r <= 32'h00000000;
      end else if (accept && !hwrite) begin
         hrdata_r <= rd_mux;
      end
   end

   // write strobes of the data phase
   always_comb begin
      wr_flags = 1'b0;
      wr_mask = 1'b0;
      wr_ctrl = 1'b0;
      wr_err_mask = 1'b0;
      case (ph_r)
         PH_WRITE: begin
            wr_flags = addr_r == OFS_FLAGS;
            wr_mask = addr_r == OFS_MASK;
            wr_ctrl = addr_r == OFS_CTRL;
            wr_err_mask = addr_r == OFS_ERR_MASK;
         end
         PH_IDLE, PH_READ: begin
            wr_flags = 1'b0;
         end
         default: begin
            wr_flags = 1'b0;
         end
      endcase
   end

   // ***********************************************
   // control and mask registers
   // ***********************************************
   always_ff @(posedge clock or posedge sys_rst) begin
      if (sys_rst) begin
         mask_r <= MASK_RESET;
         host_en_r <= CTRL_RESET;
         err_mask_r <= ERR_W'(ERR_MASK_RESET);
      end else begin
         if (wr_mask) begin
            mask_r <= hwdata[7:0];
         end
         if (wr_ctrl) begin
            host_en_r <= hwdata[BIT_HOST_EN];
         end
         if (wr_err_mask) begin
            err_mask_r <= hwdata[ERR_W-1:0];
         end
      end
   end
   assign host_role_enable = host_en_r;

   // ***********************************************
   // line state timing
   // ***********************************************
   line_state_monitor #(
      .QUIET_CYCLES(QUIET_CYCLES),
      .IDLE_CYCLES(IDLE_CYCLES),
      .CNT_W(20)
   ) u_line (
      .clock(clock),
      .sys_rst(sys_rst),
      .line_state(line_state),
      .bus_activity(bus_activity),
      .host_en(host_en_r),
      .attached(attached),
      .attach_evt(attach_evt),
      .detach_evt(detach_evt),
      .resume_evt(resume_evt),
      .idle_evt(idle_evt)
   );

   // ***********************************************
   // transfer status fifo
   // ***********************************************
   // a full fifo stalls the token engine rather than losing an entry
   assign token_ready = count_r != CNT_W'(XFER_DEPTH);
   assign push = token_done && token_ready;
   assign pop = wr_flags && hwdata[BIT_TOKEN] && count_r != '0;

   always_ff @(posedge clock or posedge sys_rst) begin
      if (sys_rst) begin
         wr_ptr_r <= '0;
         rd_ptr_r <= '0;
         count_r <= '0;
      end else begin
         if (push) begin
            wr_ptr_r <= (wr_ptr_r == PTR_W'(XFER_DEPTH - 1)) ? '0 : wr_ptr_r + PTR_W'(1);
         end
         if (pop) begin
            rd_ptr_r <= (rd_ptr_r == PTR_W'(XFER_DEPTH - 1)) ? '0 : rd_ptr_r + PTR_W'(1);
         end
         if (push && !pop) begin
            count_r <= count_r + CNT_W'(1);
         end else if (pop && !push) begin
            count_r <= count_r - CNT_W'(1);
         end
      end
   end

   // entry storage, written at the push pointer
   always_ff @(posedge clock) begin
      if (push) begin
         stat_mem_r[wr_ptr_r] <= token_status;
      end
   end

   // ***********************************************
   // event flags
   // ***********************************************
   // role decides the source of bits 7, 2 and 0
   always_comb begin
      flag_set = 8'h00;
      flag_set[BIT_STALL] = host_en_r ? stall_rx : stall_tx;
      flag_set[BIT_ATTACH] = attach_evt;
      flag_set[BIT_RESUME] = resume_evt;
      flag_set[BIT_IDLE] = idle_evt;
      // a further queued entry re-raises the flag as the head moves on
      flag_set[BIT_TOKEN] = push || (pop && count_r > CNT_W'(1));
      flag_set[BIT_SOF] = host_en_r ? sof_threshold : sof_rx;
      flag_set[BIT_ERROR] = |(error_events & err_mask_r);
      flag_set[BIT_RST_DET] = host_en_r ? detach_evt : usb_reset_rx;
   end

   // software clears by writing ones; the attach bit ignores writes
   always_comb begin
      flag_clr = wr_flags ? (hwdata[7:0] & FLAG_W1C_MASK) : 8'h00;
      // attach is read-only: it drops when the peripheral leaves or host role ends
      flag_clr[BIT_ATTACH] = detach_evt || !host_en_r;
      flags_nxt = flag_set | (flags_r & ~flag_clr);
   end

   always_ff @(posedge clock or posedge sys_rst) begin
      if (sys_rst) begin
         flags_r <= FLAGS_RESET;
      end else begin
         flags_r <= flags_nxt;
      end
   end

   // level interrupt; resume should stay masked unless suspended
   assign irq = |(flags_r & mask_r);

   // ***********************************************
   // checks
   // ***********************************************
   default clocking cb @(posedge clock); endclocking
   default disable iff (sys_rst);

   sequence s_token_clear;
      wr_flags && hwdata[BIT_TOKEN] && count_r > CNT_W'(1) && !push;
   endsequence

   sequence s_flag_write(int b);
      wr_flags && hwdata[b];
   endsequence

   a_stall_host: assert property (
      host_en_r && stall_rx |=> flags_r[BIT_STALL])
      else $error("stall received as host not flagged");
   a_stall_func: assert property (
      !host_en_r && stall_tx |=> flags_r[BIT_STALL])
      else $error("stall sent as function not flagged");
   a_attach_ro: assert property (
      s_flag_write(BIT_ATTACH) ##0 (flags_r[BIT_ATTACH] && host_en_r && !detach_evt)
      |=> flags_r[BIT_ATTACH])
      else $error("attach flag cleared by a write");
   a_token_entry: assert property (
      push && count_r == '0 |=> flags_r[BIT_TOKEN] && stat_mem_r[rd_ptr_r] == $past(token_status))
      else $error("token entry not presented");
   a_fifo_advance: assert property (
      s_token_clear |=> count_r == $past(count_r) - CNT_W'(1) && flags_r[BIT_TOKEN])
      else $error("status fifo did not advance");
   a_sof_role: assert property (
      (host_en_r ? sof_threshold : sof_rx) |=> flags_r[BIT_SOF])
      else $error("start of frame not flagged");
   a_error_sum: assert property (
      |(error_events & err_mask_r) |=> flags_r[BIT_ERROR])
      else $error("unmasked error not flagged");
   a_bit0_role: assert property (
      (host_en_r ? detach_evt : usb_reset_rx) |=> flags_r[BIT_RST_DET])
      else $error("reset or detach not flagged");
   a_set_wins: assert property (
      s_flag_write(BIT_STALL) ##0 (host_en_r ? stall_rx : stall_tx) |=> flags_r[BIT_STALL])
      else $error("clear beat a simultaneous set");
   a_flag_holds: assert property (
      flags_r[BIT_IDLE] && !(wr_flags && hwdata[BIT_IDLE]) |=> flags_r[BIT_IDLE])
      else $error("idle flag dropped without a clear");
   a_upper_zero: assert property (
      accept && !hwrite && haddr == 32'(OFS_FLAGS) |=> hrdata[31:8] == 24'h000000)
      else $error("upper flag bits not zero");
   a_irq_level: assert property (
      (flags_r & mask_r) != 8'h00 |-> irq)
      else $error("interrupt low with unmasked flag");

   // line events reach the flag register one edge after the hold time is met
   a_resume_flag: assert property (
      resume_evt |=> flags_r[BIT_RESUME])
      else $error("resume not flagged");
   a_idle_flag: assert property (
      idle_evt |=> flags_r[BIT_IDLE])
      else $error("idle not flagged");
   a_attach_flag: assert property (
      attach_evt |=> flags_r[BIT_ATTACH])
      else $error("attachment not flagged");

   // a full fifo refuses new entries, so only a pop may lower the count
   a_full_holds: assert property (
      count_r == CNT_W'(XFER_DEPTH) && !pop |=> count_r == CNT_W'(XFER_DEPTH))
      else $error("full status fifo changed without a pop");
endmodule
`default_nettype wire

// file: bench/usb_far_end.sv
// partner model: remote usb party driving line state and event pulses
`default_nettype none
module usb_far_end
   import usb_flag_pkg::*;
(
   input wire logic clock,
   input wire logic token_ready,
   output logic [1:0] line_state,
   output logic bus_activity,
   output logic stall_rx,
   output logic stall_tx,
   output logic token_done,
   output logic [7:0] token_status,
   output logic sof_rx,
   output logic sof_threshold,
   output logic [7:0] error_events,
   output logic usb_reset_rx
);
   timeunit 1ns;
   timeprecision 1ps;

   // ***********************************************
   // quiet bus at start: se0 line, no traffic
   // ***********************************************
   initial begin
      line_state = LS_SE0;
      bus_activity = 1'b0;
      {stall_rx, stall_tx, token_done, sof_rx, sof_threshold, usb_reset_rx} = 6'h00;
      token_status = 8'h00;
      error_events = 8'h00;
   end

   // one-cycle event pulse, launched just after an edge
   task automatic pulse(input int idx, input logic [7:0] err);
      case (idx)
         0: stall_tx <= 1'b1;
         1: stall_rx <= 1'b1;
         2: sof_rx <= 1'b1;
         3: sof_threshold <= 1'b1;
         4: usb_reset_rx <= 1'b1;
         default: error_events <= err;
      endcase
      @(posedge clock);
      {stall_rx, stall_tx, sof_rx, sof_threshold, usb_reset_rx} <= 5'h00;
      error_events <= 8'h00;
   endtask

   // finished token, held until the fifo takes it; status carries junk once released
   task automatic token(input logic [7:0] s);
      int n;
      n = 0;
      token_done <= 1'b1;
      token_status <= s;
      do begin
         @(posedge clock);
         n++;
      end while (token_ready !== 1'b1 && n < 100);
      token_done <= 1'b0;
      token_status <= ~s;
      // one quiet edge so a following call never re-raises the strobe in this step
      @(posedge clock);
   endtask

   // hold one line state with no packet traffic
   task automatic hold(input logic [1:0] ls, input int cyc);
      line_state <= ls;
      repeat (cyc) @(posedge clock);
   endtask
endmodule
`default_nettype wire

// file: bench/tb.sv
// testbench: register access and event scenarios for the usb event flag block
`default_nettype none
module tb
   import usb_flag_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;

   // ***********************************************
   // signals and instances
   // ***********************************************
   logic clock, sys_rst, hsel, hwrite, hready, hreadyout, hresp, irq;
   logic [31:0] haddr, hwdata, hrdata;
   logic [1:0] htrans, line_state;
   logic [2:0] hsize;
   logic bus_activity, stall_rx, stall_tx, token_done, token_ready;
   logic sof_rx, sof_threshold, usb_reset_rx, host_role_enable;
   logic [7:0] token_status, error_events;
   int miscompares = 0;
   int checks_done = 0;
   int evbit[6] = '{BIT_STALL, BIT_STALL, BIT_SOF, BIT_SOF, BIT_RST_DET, BIT_ERROR};

   // single slave: its ready is the bus ready
   assign hready = hreadyout;

   usb_event_flag_register #(.QUIET_CYCLES(8), .IDLE_CYCLES(50), .XFER_DEPTH(4),
      .STAT_W(8), .ERR_W(8)) dut (
      .clock(clock), .sys_rst(sys_rst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
      .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
      .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp), .line_state(line_state),
      .bus_activity(bus_activity), .stall_rx(stall_rx), .stall_tx(stall_tx),
      .token_done(token_done), .token_status(token_status), .token_ready(token_ready),
      .sof_rx(sof_rx), .sof_threshold(sof_threshold), .error_events(error_events),
      .usb_reset_rx(usb_reset_rx), .host_role_enable(host_role_enable), .irq(irq));

   usb_far_end far (
      .clock(clock), .token_ready(token_ready), .line_state(line_state),
      .bus_activity(bus_activity), .stall_rx(stall_rx), .stall_tx(stall_tx),
      .token_done(token_done), .token_status(token_status), .sof_rx(sof_rx),
      .sof_threshold(sof_threshold), .error_events(error_events),
      .usb_reset_rx(usb_reset_rx));

   // ***********************************************
   // bus tasks and comparison
   // ***********************************************
   task automatic check(input string nm, input logic [31:0] exp, input logic [31:0] got);
      checks_done++;
      if (got !== exp) begin
         miscompares++;
         $display("BAD %s expected %h seen %h", nm, exp, got);
      end
   endtask

   // one ahb-lite single transfer; entered just after a rising edge
   task automatic xfer(input logic [7:0] a, input logic wr, input logic [2:0] sz,
      input logic [31:0] wd, output logic [31:0] rd);
      hsel <= 1'b1;
      htrans <= 2'h2;
      haddr <= {24'h000000, a};
      hwrite <= wr;
      hsize <= sz;
      do @(posedge clock); while (hready !== 1'b1);
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= wd;
      do @(posedge clock); while (hready !== 1'b1);
      rd = hrdata;
      check("hresp", 32'h00000000, {31'h0, hresp});
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] x;
      xfer(a, 1'b1, SIZE_WORD, d, x);
   endtask

   task automatic rd(input logic [7:0] a, input logic [31:0] exp, input string nm);
      logic [31:0] x;
      xfer(a, 1'b0, SIZE_WORD, 32'h00000000, x);
      check(nm, exp, x);
   endtask

   // ***********************************************
   // closing and watchdog
   // ***********************************************
   task automatic end_of_test();
      $display("checks %0d mismatches %0d", checks_done, miscompares);
      if (miscompares == 0 && checks_done > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask

   // the whole run takes about 270 cycles
   initial begin
      repeat (20000) @(posedge clock);
      miscompares++;
      end_of_test();
   end

   initial begin
      clock = 1'b0;
      forever #4 clock = ~clock;
   end

   // ***********************************************
   // scenarios
   // ***********************************************
   initial begin
      logic [31:0] x;
      logic h;
      sys_rst = 1'b1;
      {hsel, hwrite, htrans, hsize} = 7'h00;
      haddr = 32'h00000000;
      hwdata = 32'h00000000;
      repeat (10) @(posedge clock);
      sys_rst <= 1'b0;
      @(posedge clock);
      // reset values, then an unmapped place and a byte write that must be ignored
      rd(OFS_FLAGS, 32'h00000000, "flags");
      rd(OFS_MASK, 32'h00000000, "mask");
      rd(OFS_CTRL, 32'h00000000, "ctrl");
      rd(OFS_ERR_MASK, {24'h000000, ERR_MASK_RESET}, "err mask");
      rd(OFS_XFER_STAT, 32'h00000000, "status");
      wr(8'h40, 32'hFFFFFFFF);
      rd(8'h40, 32'h00000000, "unmapped");
      wr(OFS_MASK, 32'hFFFFFFFF);
      xfer(OFS_MASK, 1'b1, 3'h0, 32'h00000000, x);
      rd(OFS_MASK, 32'h000000FF, "mask");
      // every stall, sof and bus reset source and error bit 0, in the role that owns it: set, irq, write-one clear
      for (int i = 0; i < 6; i++) begin
         h = (i == 1 || i == 3);
         wr(OFS_CTRL, {31'h0, h});
         // the role output settles after the edge that ends the write
         @(posedge clock);
         check("role", {31'h0, h}, {31'h0, host_role_enable});
         far.pulse(i, 8'h01);
         rd(OFS_FLAGS, 32'h1 << evbit[i], "flags");
         check("irq", 32'h00000001, {31'h0, irq});
         wr(OFS_FLAGS, 32'h1 << evbit[i]);
         rd(OFS_FLAGS, 32'h00000000, "flags");
         check("irq", 32'h00000000, {31'h0, irq});
      end
      // a masked error condition leaves the summary flag alone
      wr(OFS_ERR_MASK, 32'h000000FE);
      far.pulse(5, 8'h01);
      rd(OFS_FLAGS, 32'h00000000, "err masked");
      far.pulse(5, 8'h02);
      rd(OFS_FLAGS, 32'h1 << BIT_ERROR, "err open");
      wr(OFS_FLAGS, 32'hFF);
      // masked flag keeps irq low; a set in the clearing cycle wins
      wr(OFS_MASK, 32'h0000007F);
      far.pulse(0, 8'h00);
      fork
         wr(OFS_FLAGS, 32'h00000080);
         begin
            @(posedge clock);
            far.pulse(0, 8'h00);
         end
      join
      rd(OFS_FLAGS, 32'h00000080, "set wins");
      check("irq masked", 32'h00000000, {31'h0, irq});
      wr(OFS_FLAGS, 32'h00000080);
      // status fifo: fill to refusal, then each clear exposes the next entry
      wr(OFS_MASK, 32'h000000FF);
      for (int i = 1; i <= 4; i++) far.token(8'(8'h11 * i));
      @(posedge clock);
      check("ready", 32'h00000000, {31'h0, token_ready});
      for (int i = 1; i <= 4; i++) begin
         rd(OFS_XFER_STAT, 32'(8'(8'h11 * i)), "status");
         rd(OFS_FLAGS, 32'h1 << BIT_TOKEN, "token");
         wr(OFS_FLAGS, 32'h1 << BIT_TOKEN);
      end
      rd(OFS_FLAGS, 32'h00000000, "token");
      rd(OFS_XFER_STAT, 32'h00000000, "status");
      // line timing as host: attach, read-only attach bit, resume, idle, detach
      wr(OFS_CTRL, 32'h00000001);
      wr(OFS_MASK, 32'h000000DF);
      far.hold(LS_J, 12);
      wr(OFS_FLAGS, 32'hFF);
      rd(OFS_FLAGS, 32'h1 << BIT_ATTACH, "attach");
      far.hold(LS_K, 12);
      rd(OFS_FLAGS, (32'h1 << BIT_ATTACH) | (32'h1 << BIT_RESUME), "resume");
      far.hold(LS_J, 60);
      far.hold(LS_SE0, 12);
      rd(OFS_FLAGS, (32'h1 << BIT_RESUME) | (32'h1 << BIT_IDLE) | (32'h1 << BIT_RST_DET),
         "detach");
      wr(OFS_FLAGS, 32'hFF);
      rd(OFS_FLAGS, 32'h00000000, "flags");
      // second reset in mid-run with a flag set
      far.pulse(1, 8'h00);
      sys_rst <= 1'b1;
      repeat (2) @(posedge clock);
      sys_rst <= 1'b0;
      @(posedge clock);
      rd(OFS_FLAGS, 32'h00000000, "flags");
      check("role", 32'h00000000, {31'h0, host_role_enable});
      end_of_test();
   end
endmodule
`default_nettype wire
